// File: hdl/clkgen_pkg.sv
// Constants for the CPU clock generator and clock-output divider
package clkgen_pkg;
    // Register map
    localparam logic [15:0] CLKOUT_DIV_ADDR  = 16'he902;
    localparam int          DIV_W            = 8;
    localparam logic [7:0]  CLKOUT_DIV_RESET = 8'h00;
    // Strap codes
    localparam logic [2:0]  STRAP_X4         = 3'h7;
    localparam logic [2:0]  STRAP_X3         = 3'h6;
    localparam logic [2:0]  STRAP_X8         = 3'h5;
    localparam logic [2:0]  STRAP_X5         = 3'h4;
    localparam logic [2:0]  STRAP_DIRECT     = 3'h3;
    localparam logic [2:0]  STRAP_X10        = 3'h2;
    localparam logic [2:0]  STRAP_XHALF      = 3'h1;
    localparam logic [2:0]  STRAP_X16        = 3'h0;
    // Frequency limits in kHz
    localparam int          VCO_IN_MIN_KHZ   = 1000;
    localparam int          VCO_IN_MAX_KHZ   = 3500;
    localparam int          VCO_MIN_KHZ      = 64000;
    localparam int          VCO_MAX_KHZ      = 128000;
    localparam int          CPU_MIN_KHZ      = 16000;
    localparam int          CPU_MAX_KHZ      = 64000;
    // Field widths of the decoded settings
    localparam int          PRE_W            = 3;
    localparam int          MUL_W            = 7;
    localparam int          POST_W           = 5;
    typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} clkout_state_t;
endpackage

// File: hdl/clkgen_top.sv
// CPU clock setting decode and programmable clock-output divider
`timescale 1ns/1ps
module clkgen_top
    import clkgen_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Strap pins, sampled at reset
    input  wire logic [2:0]  PLL_FACTOR_STRAP,
    // Crystal frequency in kHz, supplied by board configuration
    input  wire logic [16:0] CRYSTAL_KHZ,
    // Enables from the system and peripheral-bus configuration registers
    input  wire logic        CLOCK_OUTPUT_ENABLE,
    input  wire logic        MISC_FEATURES_ENABLE,
    input  wire logic        PERIPHERAL_BUS_ENABLE,
    // Peripheral-bus register port
    input  wire logic        BUS_SEL,
    input  wire logic        BUS_WR,
    input  wire logic [15:0] BUS_ADDR,
    input  wire logic [15:0] BUS_WDATA,
    output logic [15:0]      BUS_RDATA,
    output logic             BUS_ACK,
    // CPU clock stage settings
    output logic             DIRECT_DRIVE,
    output logic             OSC_AMP_ENABLE,
    output logic [PRE_W-1:0] PRESCALE_DIV,
    output logic [MUL_W-1:0] VCO_MULT,
    output logic [POST_W-1:0] POST_DIV,
    output logic             RANGE_OK,
    // Clock-output pin
    output logic             CLOCK_OUTPUT_PORT_PIN
);
    // Pin synchronisers
    logic [2:0]        strap_m_q;
    logic [2:0]        strap_s_q;
    logic [2:0]        en_m_q;
    logic [2:0]        en_s_q;
    logic [16:0]       xtal_m_q;
    logic [16:0]       xtal_s_q;
    // Captured settings
    logic [2:0]        strap_q;
    logic [2:0]        strap_d;
    logic              direct_q;
    logic              direct_d;
    logic              osc_q;
    logic              osc_d;
    logic [PRE_W-1:0]  pre_q;
    logic [PRE_W-1:0]  pre_d;
    logic [MUL_W-1:0]  mul_q;
    logic [MUL_W-1:0]  mul_d;
    logic [POST_W-1:0] post_q;
    logic [POST_W-1:0] post_d;
    logic              ok_q;
    logic              ok_d;
    // Register state
    logic [DIV_W-1:0]  div_q;
    logic [DIV_W-1:0]  div_d;
    logic [15:0]       rdata_q;
    logic [15:0]       rdata_d;
    logic              ack_q;
    logic              ack_d;
    logic              pin_q;
    logic              pin_d;
    logic              level;
    logic              access_ok;
    logic              hit;
    int                vco_in;
    int                vco;
    int                cpu;

    // Two-stage capture of all pin inputs
    always_ff @(posedge CLK) begin
        strap_m_q <= PLL_FACTOR_STRAP;
        strap_s_q <= strap_m_q;
        en_m_q    <= {CLOCK_OUTPUT_ENABLE, MISC_FEATURES_ENABLE, PERIPHERAL_BUS_ENABLE};
        en_s_q    <= en_m_q;
        xtal_m_q  <= CRYSTAL_KHZ;
        xtal_s_q  <= xtal_m_q;
    end

    // Strap catch: follows the synchronised strap while reset is high, frozen after release
    always_comb begin
        strap_d = strap_q;
        if (SYS_RST) begin
            strap_d = strap_s_q;
        end
    end

    // Stage settings per strap code: prescale, multiply, post-divide
    always_comb begin
        direct_d = 1'b0;
        pre_d    = 3'h1;
        mul_d    = 7'h01;
        post_d   = 5'h01;
        unique case (strap_q)
            STRAP_X4: begin
                pre_d  = 3'h4;
                mul_d  = 7'h40;
                post_d = 5'h04;
            end
            STRAP_X3: begin
                pre_d  = 3'h4;
                mul_d  = 7'h30;
                post_d = 5'h04;
            end
            STRAP_X8: begin
                pre_d  = 3'h4;
                mul_d  = 7'h40;
                post_d = 5'h02;
            end
            STRAP_X5: begin
                pre_d  = 3'h4;
                mul_d  = 7'h28;
                post_d = 5'h02;
            end
            STRAP_DIRECT: begin
                direct_d = 1'b1;
            end
            STRAP_X10: begin
                pre_d  = 3'h4;
                mul_d  = 7'h28;
                post_d = 5'h01;
            end
            STRAP_XHALF: begin
                pre_d  = 3'h4;
                mul_d  = 7'h20;
                post_d = 5'h10;
            end
            STRAP_X16: begin
                pre_d  = 3'h4;
                mul_d  = 7'h40;
                post_d = 5'h01;
            end
        endcase
        osc_d = ~direct_d;
    end

    // Frequency plan check across prescaler, VCO and post-divider
    always_comb begin
        vco_in = int'(xtal_s_q) / int'(pre_q);
        vco    = vco_in * int'(mul_q);
        cpu    = vco / int'(post_q);
        if (direct_q) begin
            ok_d = 1'b1;
        end else begin
            ok_d = (vco_in >= VCO_IN_MIN_KHZ) && (vco_in <= VCO_IN_MAX_KHZ)
                && (vco >= VCO_MIN_KHZ) && (vco <= VCO_MAX_KHZ)
                && (cpu >= CPU_MIN_KHZ) && (cpu <= CPU_MAX_KHZ);
        end
    end

    // Register port; divider is only reachable with both enables set
    always_comb begin
        access_ok = en_s_q[1] & en_s_q[0];
        hit       = BUS_SEL && (BUS_ADDR == CLKOUT_DIV_ADDR) && access_ok;
        div_d     = div_q;
        rdata_d   = 16'h0000;
        ack_d     = BUS_SEL;
        if (hit && BUS_WR) begin
            div_d = BUS_WDATA[DIV_W-1:0];
        end
        if (hit && !BUS_WR) begin
            rdata_d = {{(16-DIV_W){1'b0}}, div_q};
        end
        // Without both enables the register is not visible; reads give zero
        pin_d = en_s_q[2] ? level : 1'b0;
    end

    clkout_counter #(
        .W(DIV_W)
    ) u_counter (
        .clk  (CLK),
        .rst  (SYS_RST),
        .run  (en_s_q[2]),
        .div  (div_q),
        .level(level)
    );

    always_ff @(posedge CLK) begin
        strap_q <= strap_d;
        if (SYS_RST) begin
            direct_q <= 1'b0;
            osc_q    <= 1'b1;
            pre_q    <= 3'h1;
            mul_q    <= 7'h01;
            post_q   <= 5'h01;
            ok_q     <= 1'b0;
            div_q    <= CLKOUT_DIV_RESET;
            rdata_q  <= 16'h0000;
            ack_q    <= 1'b0;
            pin_q    <= 1'b0;
        end else begin
            direct_q <= direct_d;
            osc_q    <= osc_d;
            pre_q    <= pre_d;
            mul_q    <= mul_d;
            post_q   <= post_d;
            ok_q     <= ok_d;
            div_q    <= div_d;
            rdata_q  <= rdata_d;
            ack_q    <= ack_d;
            pin_q    <= pin_d;
        end
    end

    assign DIRECT_DRIVE          = direct_q;
    assign OSC_AMP_ENABLE        = osc_q;
    assign PRESCALE_DIV          = pre_q;
    assign VCO_MULT              = mul_q;
    assign POST_DIV              = post_q;
    assign RANGE_OK              = ok_q;
    assign BUS_RDATA             = rdata_q;
    assign BUS_ACK               = ack_q;
    assign CLOCK_OUTPUT_PORT_PIN = pin_q;
endmodule

// File: hdl/clkout_counter.sv
// Divide-by-(N+1) counter producing a square clock-output level; N=0 divides by 2
`timescale 1ns/1ps
module clkout_counter
    import clkgen_pkg::*;
#(
    parameter int W = DIV_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         run,
    input  wire logic [W-1:0] div,
    // Output level
    output logic              level
);
    logic [W:0] cnt_q;
    logic [W:0] cnt_d;
    logic       level_q;
    logic       level_d;
    logic [W:0] period;

    assign level = level_q;

    always_comb begin
        period  = {1'b0, div} + {{W{1'b0}}, 1'b1};
        cnt_d   = cnt_q;
        level_d = level_q;
        if (!run) begin
            cnt_d   = '0;
            level_d = 1'b0;
        end else if (div == '0) begin
            // Undivided: one full period per two ticks, toggling each tick
            cnt_d   = '0;
            level_d = ~level_q;
        end else if (cnt_q == period - {{W{1'b0}}, 1'b1}) begin
            cnt_d   = '0;
            level_d = 1'b1;
        end else begin
            cnt_d   = cnt_q + {{W{1'b0}}, 1'b1};
            // High for the first half of the period, rounded down
            level_d = ((cnt_q + {{W{1'b0}}, 1'b1}) < (period >> 1)) ? 1'b1 : 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end
endmodule

// File: testbench/clkgen_chk.sv
// Port checks of the clock generator
`timescale 1ns/1ps
module clkgen_chk
    import clkgen_pkg::*;
(
    // Clock and reset
    input wire logic              CLK,
    input wire logic              SYS_RST,
    // Bus
    input wire logic              BUS_SEL,
    input wire logic [15:0]       BUS_ADDR,
    input wire logic              BUS_ACK,
    input wire logic [15:0]       BUS_RDATA,
    // Settings and pin
    input wire logic              DIRECT_DRIVE,
    input wire logic              OSC_AMP_ENABLE,
    input wire logic [PRE_W-1:0]  PRESCALE_DIV,
    input wire logic [MUL_W-1:0]  VCO_MULT,
    input wire logic [POST_W-1:0] POST_DIV,
    input wire logic              CLOCK_OUTPUT_ENABLE,
    input wire logic              CLOCK_OUTPUT_PORT_PIN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic [2:0] up_q, up_d;
    logic [8:0] hi_q, hi_d;
    // Settle counter; strap is frozen at release, settings load on the first edge after it
    always_comb begin
        up_d = SYS_RST ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
        hi_d = CLOCK_OUTPUT_PORT_PIN ? hi_q + 9'h001 : 9'h000;
    end
    always_ff @(posedge CLK) begin
        up_q <= up_d;
        hi_q <= hi_d;
    end
    property p_ack; BUS_SEL |=> BUS_ACK; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_noack; !BUS_SEL |=> !BUS_ACK; endproperty
    a_noack: assert property (p_noack) else $error("stray ack");
    property p_upper; BUS_ACK |-> BUS_RDATA[15:8] == 8'h00; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_miss; BUS_SEL && BUS_ADDR != CLKOUT_DIV_ADDR |=> BUS_RDATA == 16'h0000; endproperty
    a_miss: assert property (p_miss) else $error("miss read nonzero");
    property p_osc; OSC_AMP_ENABLE != DIRECT_DRIVE; endproperty
    a_osc: assert property (p_osc) else $error("amplifier state wrong");
    property p_hold; up_q == 3'h7 |-> $stable({PRESCALE_DIV, VCO_MULT, POST_DIV}); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_off; !CLOCK_OUTPUT_ENABLE [*6] |-> !CLOCK_OUTPUT_PORT_PIN; endproperty
    a_off: assert property (p_off) else $error("pin active when off");
    property p_half; hi_q <= 9'h080; endproperty
    a_half: assert property (p_half) else $error("high phase too long");
    c_direct: cover property (DIRECT_DRIVE);
    c_rise: cover property ($rose(CLOCK_OUTPUT_PORT_PIN));
    c_miss: cover property (BUS_SEL && BUS_ADDR != CLKOUT_DIV_ADDR);
endmodule

// File: testbench/tb.sv
// Self-checking bench for the clock generator
`timescale 1ns/1ps
module tb
    import clkgen_pkg::*;
;
    logic clk, rst, sel, wr, cen, men, pen, ack, dd, osc, rok, pin, seen;
    logic [2:0] strap;
    logic [16:0] xtal;
    logic [15:0] addr, wd, rd, r;
    logic [PRE_W-1:0] pre;
    logic [MUL_W-1:0] mul;
    logic [POST_W-1:0] post;
    int num_errors, check_count, c, v;
    // Crystal per strap code, chosen inside each factor's input range
    int xt[8] = '{4000, 8000, 6400, 8000, 8000, 8000, 8000, 8000};
    int f2[8] = '{32, 1, 20, 2, 10, 16, 6, 8};
    logic [7:0] dv[3] = '{8'h01, 8'h05, 8'hff};
    clkgen_top dut(.CLK(clk), .SYS_RST(rst), .PLL_FACTOR_STRAP(strap), .CRYSTAL_KHZ(xtal),
        .CLOCK_OUTPUT_ENABLE(cen), .MISC_FEATURES_ENABLE(men), .PERIPHERAL_BUS_ENABLE(pen),
        .BUS_SEL(sel), .BUS_WR(wr), .BUS_ADDR(addr), .BUS_WDATA(wd), .BUS_RDATA(rd),
        .BUS_ACK(ack), .DIRECT_DRIVE(dd), .OSC_AMP_ENABLE(osc), .PRESCALE_DIV(pre),
        .VCO_MULT(mul), .POST_DIV(post), .RANGE_OK(rok), .CLOCK_OUTPUT_PORT_PIN(pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        sel <= 1'b0;
        #1;
        chk(ack, 1);
        r = rd;
    endtask
    task automatic do_reset(input logic [2:0] s, input int x);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        xtal <= 17'(x);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Cycles up to the next rising pin edge, bounded
    task automatic rise;
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (pin !== 1'b0 && c < 600);
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (pin !== 1'b1 && c < 600);
        if (c >= 600) begin
            num_errors++;
            stop_test();
        end
    endtask
    initial begin
        {rst, cen, men, pen} = 4'hf;
        {sel, wr, addr, wd, strap, xtal} = '0;
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s), xt[s]);
            #1;
            chk(dd, s == 3);
            chk(osc, s != 3);
            if (s != 3) begin
                chk(2 * mul, f2[s] * pre * post);
                chk(xtal / pre >= 1000 && xtal / pre <= 3500, 1);
                v = int'(xtal) * mul / pre;
                chk(v >= 64000 && v <= 128000, 1);
                if (s != 1) chk(v / post >= 16000 && v / post <= 64000 && rok, 1);
            end
            bus(0, CLKOUT_DIV_ADDR, 16'h0000);
            chk(r, CLKOUT_DIV_RESET);
            rise();
            rise();
            chk(c, 2);
            $display("strap %0d done", s);
        end
        foreach (dv[i]) begin
            bus(1, CLKOUT_DIV_ADDR, {8'h5a, dv[i]});
            bus(0, CLKOUT_DIV_ADDR, 16'h0000);
            chk(r, {8'h00, dv[i]});
            repeat (3) rise();
            chk(c, dv[i] < 2 ? 2 : dv[i] + 1);
        end
        $display("divider done");
        // Refused writes must leave the field alone
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            men <= k != 1;
            pen <= k != 2;
            repeat (3) @(posedge clk);
            bus(1, k == 0 ? 16'he904 : CLKOUT_DIV_ADDR, 16'h0033);
            bus(0, k == 0 ? 16'he904 : CLKOUT_DIV_ADDR, 16'h0000);
            chk(r, 16'h0000);
        end
        @(posedge clk);
        {men, pen} <= 2'h3;
        repeat (3) @(posedge clk);
        bus(0, CLKOUT_DIV_ADDR, 16'h0000);
        chk(r, 16'h00ff);
        $display("refusal done");
        @(posedge clk);
        cen <= 1'b0;
        repeat (8) @(posedge clk);
        // Four-state accumulator so an unknown pin level is not lost
        seen = 1'b0;
        repeat (40) begin
            @(posedge clk);
            #1;
            seen = seen | pin;
        end
        chk(seen, 1'b0);
        $display("disable done");
        stop_test();
    end
endmodule
bind clkgen_top clkgen_chk chk(.CLK(CLK), .SYS_RST(SYS_RST), .BUS_SEL(BUS_SEL),
    .BUS_ADDR(BUS_ADDR), .BUS_ACK(BUS_ACK), .BUS_RDATA(BUS_RDATA),
    .DIRECT_DRIVE(DIRECT_DRIVE), .OSC_AMP_ENABLE(OSC_AMP_ENABLE),
    .PRESCALE_DIV(PRESCALE_DIV), .VCO_MULT(VCO_MULT), .POST_DIV(POST_DIV),
    .CLOCK_OUTPUT_ENABLE(CLOCK_OUTPUT_ENABLE), .CLOCK_OUTPUT_PORT_PIN(CLOCK_OUTPUT_PORT_PIN));
